/* File: rtl/prf_consts.svh */
// constants for the peripheral request flags block
// assumes an apb slave at 32-bit data, one aligned word per register
`ifndef PRF_CONSTS_SVH
`define PRF_CONSTS_SVH
`define PRF_FLAGS_ADDR   12'h000
`define PRF_FLAGS_RESET  8'h00
`define PRF_OSC_BIT      7
`define PRF_CSW_BIT      6
`define PRF_ADC_BIT      0
`define PRF_IMPL_MASK    8'hc1
`endif

/* File: rtl/prf_pkg.sv */
// types for the peripheral request flags block
// assumes nothing beyond the constants header
package prf_pkg;
    // one event pulse per flag source
    typedef struct packed {
        logic osc_fail;
        logic clk_switch_ready;
        logic conversion_done;
    } prf_events_s;
endpackage

/* File: rtl/prf_request_flags.sv */
// peripheral request flag register one behind an apb slave
// assumes event inputs are one-cycle pulses synchronous to sys_clk_i
// assumes software reaches the flags through byte lane zero; the upper lanes are ignored
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ns
`include "prf_consts.svh"
module prf_request_flags
(
    input  wire logic               sys_clk_i,
    input  wire logic               sys_rst_i,
    input  wire logic               psel_i,
    input  wire logic               penable_i,
    input  wire logic               pwrite_i,
    input  wire logic [11:0]        paddr_i,
    input  wire logic [31:0]        pwdata_i,
    input  wire logic [3:0]         pstrb_i,
    input  wire prf_pkg::prf_events_s events_i,
    output logic      [31:0]        prdata_o,
    output logic                    pready_o,
    output logic                    pslverr_o,
    output logic      [7:0]         flags_o
);
    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic       setup_hit;
    logic       wr_en;
    logic [7:0] set_vec;
    logic [7:0] flags_q;
    logic [7:0] flags_d;
    logic       hit;

    // pready answers one cycle after setup, so every access completes without a wait state
    assign setup_hit = psel_i && !penable_i;
    assign hit       = (paddr_i == `PRF_FLAGS_ADDR);
    assign wr_en     = psel_i && penable_i && pready_o && pwrite_i && hit && pstrb_i[0];

    // a refused write leaves the flags to the events alone, so no stale clear slips through
    property p_unmapped_ignored;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (psel_i && penable_i && pready_o && pwrite_i && !hit)
            |=> (flags_q == $past(flags_q | set_vec));
    endproperty
    a_unmapped_ignored: assert property (p_unmapped_ignored) else $error("unmapped write changed flags");

    property p_strobe_guard;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (psel_i && penable_i && pready_o && pwrite_i && hit && !pstrb_i[0])
            |=> (flags_q == $past(flags_q | set_vec));
    endproperty
    a_strobe_guard: assert property (p_strobe_guard) else $error("write without lane zero stored");

    // ------------------------------------------------------------
    // flag register
    // ------------------------------------------------------------
    // events ignore every enable, no enable input exists here
    always_comb
    begin
        set_vec = 8'h00;
        set_vec[`PRF_OSC_BIT] = events_i.osc_fail;
        set_vec[`PRF_CSW_BIT] = events_i.clk_switch_ready;
        set_vec[`PRF_ADC_BIT] = events_i.conversion_done;
        flags_d = flags_q;
        if (wr_en)
        begin
            flags_d = pwdata_i[7:0];
        end
        // set wins over a same-cycle software clear; unused bits masked
        flags_d = (flags_d | set_vec) & `PRF_IMPL_MASK;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            flags_q <= `PRF_FLAGS_RESET;
        end
        else
        begin
            flags_q <= flags_d;
        end
    end

    // every reset clears the whole register, whatever was pending
    property p_rst_flags;
        @(posedge sys_clk_i)
        sys_rst_i |=> (flags_q == `PRF_FLAGS_RESET);
    endproperty
    a_rst_flags: assert property (p_rst_flags) else $error("flags not cleared by reset");

    // nothing on the bus and no event: the register keeps its value
    property p_idle_hold;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (!wr_en && set_vec == 8'h00) |=> (flags_q == $past(flags_q));
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("flags moved with no cause");

    // an event in the cycle of a clearing write still leaves its flag set
    property p_set_beats_clear;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (wr_en && set_vec != 8'h00) |=> ((flags_q & $past(set_vec)) == $past(set_vec));
    endproperty
    a_set_beats_clear: assert property (p_set_beats_clear) else $error("event lost to clear");

    // software may set any implemented flag by writing one
    property p_sw_sets;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        wr_en |=> ((flags_q & $past(pwdata_i[7:0]) & `PRF_IMPL_MASK) == ($past(pwdata_i[7:0]) & `PRF_IMPL_MASK));
    endproperty
    a_sw_sets: assert property (p_sw_sets) else $error("written one not stored");

    // a written zero clears a flag whose event is quiet in that cycle
    property p_osc_clear;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (wr_en && !pwdata_i[`PRF_OSC_BIT] && !events_i.osc_fail) |=> !flags_q[`PRF_OSC_BIT];
    endproperty
    a_osc_clear: assert property (p_osc_clear) else $error("osc flag not cleared");

    property p_csw_clear;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (wr_en && !pwdata_i[`PRF_CSW_BIT] && !events_i.clk_switch_ready) |=> !flags_q[`PRF_CSW_BIT];
    endproperty
    a_csw_clear: assert property (p_csw_clear) else $error("switch flag not cleared");

    property p_adc_clear;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (wr_en && !pwdata_i[`PRF_ADC_BIT] && !events_i.conversion_done) |=> !flags_q[`PRF_ADC_BIT];
    endproperty
    a_adc_clear: assert property (p_adc_clear) else $error("adc flag not cleared");

    // the failure and switch flags never rise without their event or a write
    property p_osc_quiet;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (!events_i.osc_fail && !wr_en && !flags_q[`PRF_OSC_BIT]) |=> !flags_q[`PRF_OSC_BIT];
    endproperty
    a_osc_quiet: assert property (p_osc_quiet) else $error("osc flag rose alone");

    property p_csw_quiet;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (!events_i.clk_switch_ready && !wr_en && !flags_q[`PRF_CSW_BIT]) |=> !flags_q[`PRF_CSW_BIT];
    endproperty
    a_csw_quiet: assert property (p_csw_quiet) else $error("switch flag rose alone");

    // mirror for downstream enable gating, registered
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            flags_o <= `PRF_FLAGS_RESET;
        end
        else
        begin
            flags_o <= flags_d;
        end
    end

    // the mirror must track the register exactly, reserved bits included
    property p_mirror;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        1'b1 |-> (flags_o == flags_q);
    endproperty
    a_mirror: assert property (p_mirror) else $error("flag mirror differs");

    property p_mirror_reserved;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        1'b1 |-> (flags_o[5:1] == 5'h00);
    endproperty
    a_mirror_reserved: assert property (p_mirror_reserved) else $error("mirror reserved bits nonzero");

    // ------------------------------------------------------------
    // apb response
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end
        else
        begin
            pready_o  <= setup_hit;
            pslverr_o <= setup_hit && !hit;
            if (setup_hit && !pwrite_i && hit)
            begin
                prdata_o <= {24'h00_0000, flags_q};
            end
            else
            begin
                prdata_o <= 32'h0000_0000;
            end
        end
    end

    // reset drops every bus output
    property p_rst_bus;
        @(posedge sys_clk_i)
        sys_rst_i |=> (!pready_o && !pslverr_o && prdata_o == 32'h0000_0000);
    endproperty
    a_rst_bus: assert property (p_rst_bus) else $error("bus outputs not cleared by reset");

    // ready only ever answers a setup cycle one clock earlier
    property p_ready_source;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        pready_o |-> $past(setup_hit);
    endproperty
    a_ready_source: assert property (p_ready_source) else $error("ready without setup");

    // an unmapped word answers with an error, a mapped one never does
    property p_err_unmapped;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (setup_hit && !hit) |=> pslverr_o;
    endproperty
    a_err_unmapped: assert property (p_err_unmapped) else $error("no error for unmapped word");

    property p_err_mapped;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (setup_hit && hit) |=> !pslverr_o;
    endproperty
    a_err_mapped: assert property (p_err_mapped) else $error("error on mapped word");

    // an error comes only with ready and carries no data
    property p_err_pair;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        pslverr_o |-> (pready_o && prdata_o == 32'h0000_0000);
    endproperty
    a_err_pair: assert property (p_err_pair) else $error("error without ready or with data");

    // a read returns the register as it stood at the setup edge
    property p_read_data;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (setup_hit && !pwrite_i && hit) |=> (prdata_o == {24'h00_0000, $past(flags_q)});
    endproperty
    a_read_data: assert property (p_read_data) else $error("read data wrong");

    // read data is zero whenever no read answer stands
    property p_prdata_idle;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        !pready_o |-> (prdata_o == 32'h0000_0000);
    endproperty
    a_prdata_idle: assert property (p_prdata_idle) else $error("read data outside answer");

    property p_write_no_data;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (setup_hit && pwrite_i) |=> (prdata_o == 32'h0000_0000);
    endproperty
    a_write_no_data: assert property (p_write_no_data) else $error("read data on a write");

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // each event pulse shows in its flag one clock later
    property p_osc_sets;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        events_i.osc_fail |=> flags_q[`PRF_OSC_BIT];
    endproperty
    a_osc_sets: assert property (p_osc_sets) else $error("osc flag not set");

    property p_adc_sets;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        events_i.conversion_done |=> flags_q[`PRF_ADC_BIT];
    endproperty
    a_adc_sets: assert property (p_adc_sets) else $error("adc flag not set");

    // the done flag stays low while no conversion completes and no write lands
    property p_adc_quiet;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (!events_i.conversion_done && !wr_en && !flags_q[`PRF_ADC_BIT]) |=> !flags_q[`PRF_ADC_BIT];
    endproperty
    a_adc_quiet: assert property (p_adc_quiet) else $error("adc flag rose alone");

    // hardware never clears a flag; only a write or a reset may
    property p_sticky;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        !wr_en |=> ((flags_q & $past(flags_q)) == $past(flags_q));
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag cleared by hardware");

    // a write with no event lands exactly, masked to the implemented bits
    property p_sw_write;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (wr_en && set_vec == 8'h00) |=> flags_q == ($past(pwdata_i[7:0]) & `PRF_IMPL_MASK);
    endproperty
    a_sw_write: assert property (p_sw_write) else $error("write not stored");

    property p_csw_sets;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        events_i.clk_switch_ready |=> flags_q[`PRF_CSW_BIT];
    endproperty
    a_csw_sets: assert property (p_csw_sets) else $error("switch flag not set");

    // reserved bits stay zero in the register and in read data
    property p_unused_zero;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        1'b1 |-> (flags_q[5:1] == 5'h00 && prdata_o[31:1] == {24'h00_0000, prdata_o[7:6], 5'h00});
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused bits nonzero");

    // one wait-free access: ready for exactly one cycle after setup
    property p_ready;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        setup_hit |=> pready_o ##1 !pready_o;
    endproperty
    a_ready: assert property (p_ready) else $error("pready timing wrong");
endmodule

/* File: verif/prf_request_flags_tb.sv */
// bench for the peripheral request flag register: apb master, event pulses, response scoreboard
// assumes the slave answers after one access cycle and keeps flags in bits 7, 6 and 0
`timescale 1ns/1ns
`include "prf_consts.svh"
module prf_request_flags_tb;
    logic                 clk  = 1'b0;
    logic                 rst  = 1'b1;
    logic                 psel = 1'b0;
    logic                 pen  = 1'b0;
    logic                 pwr  = 1'b0;
    logic [11:0]          pa   = 12'h000;
    logic [31:0]          pwd  = 32'h0;
    logic [3:0]           pst  = 4'h0;
    prf_pkg::prf_events_s ev   = 3'h0;
    logic [31:0]          prd;
    logic                 prdy;
    logic                 perr;
    logic [7:0]           flg;
    logic [7:0]           m    = 8'h00;
    logic [32:0]          exp_q[$];
    int                   failures  = 0;
    int                   tests_run = 0;

    prf_request_flags i_prf_request_flags (.sys_clk_i(clk), .sys_rst_i(rst), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .pstrb_i(pst), .events_i(ev), .prdata_o(prd),
        .pready_o(prdy), .pslverr_o(perr), .flags_o(flg));

    initial forever #25 clk = ~clk;

    task check_resp(input logic [32:0] e, input logic [32:0] s);
        tests_run++;
        if (s !== e)
        begin
            failures++;
            $display("unexpected response exp %h got %h", e, s);
        end
    endtask

    task check_flags(input logic [7:0] e);
        tests_run++;
        if (flg !== e)
        begin
            failures++;
            $display("unexpected flags exp %h got %h", e, flg);
        end
    endtask

    // scoreboard: every completed transfer takes the oldest note
    always @(posedge clk)
        if (psel && pen && prdy === 1'b1 && exp_q.size() > 0)
            check_resp(exp_q.pop_front(), {perr, prd});

    // one apb transfer; events held through it so a same-cycle clear must lose
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [2:0] e);
        int n;
        psel <= 1'b1; pen <= 1'b0; pwr <= w; pa <= a; pwd <= d; pst <= s; ev <= e;
        exp_q.push_back({a != `PRF_FLAGS_ADDR, (a == `PRF_FLAGS_ADDR && !w) ? {24'h0, m} : 32'h0});
        if (a == `PRF_FLAGS_ADDR && w && s[0]) m = d[7:0] & `PRF_IMPL_MASK;
        m = m | {e[2], e[1], 5'h00, e[0]};
        @(posedge clk) pen <= 1'b1;
        n = 0;
        do begin @(posedge clk); n++; end while (prdy !== 1'b1 && n < 20);
        if (prdy !== 1'b1) failures++;
        psel <= 1'b0; pen <= 1'b0; ev <= 3'h0;
        @(posedge clk);
        check_flags(m);
    endtask

    task print_verdict;
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        int          op;
        logic [31:0] d;
        void'($urandom(32'h31297966));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, `PRF_FLAGS_ADDR, 32'h0, 4'hf, 3'b000);
        // each source on its own, nothing enabled anywhere in this block
        for (int i = 0; i < 3; i++) apb(1'b1, 12'h004, 32'h0, 4'hf, 3'b001 << i);
        repeat (20) @(posedge clk);
        check_flags(m);
        apb(1'b1, `PRF_FLAGS_ADDR, 32'hffffff3e, 4'hf, 3'b000);
        apb(1'b1, `PRF_FLAGS_ADDR, 32'h0, 4'hf, 3'b100);
        repeat (60)
        begin
            op = $urandom_range(0, 3);
            d = $urandom;
            case (op)
                0: apb(1'b0, `PRF_FLAGS_ADDR, d, 4'hf, 3'b000);
                1: apb(1'b1, `PRF_FLAGS_ADDR, d, d[11:8], d[14:12]);
                default: apb(op[0], {d[27:18], 2'b00} | 12'h004, d, 4'hf, d[14:12]);
            endcase
        end
        // a second reset in mid-run must clear every flag again
        apb(1'b1, `PRF_FLAGS_ADDR, 32'hff, 4'h1, 3'b111);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        m = `PRF_FLAGS_RESET;
        @(posedge clk);
        check_flags(m); // all flags back to zero
        apb(1'b0, `PRF_FLAGS_ADDR, 32'h0, 4'hf, 3'b000);
        print_verdict;
    end

    // hang guard: the sequence needs a few hundred cycles
    initial
    begin
        #100000;
        failures++;
        print_verdict;
    end
endmodule
